// *** rtl/crmc_sync.sv ***
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes the inputs are levels that hold for several clock periods.
`default_nettype none

module crmc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Levels from pins and levels in the clock domain.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // The first stage feeds only the second stage.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

`default_nettype wire

// *** rtl/crmc_top.sv ***
// Reset, ROM select, bus status, write strobe and ready generation for the CPU companion.
// Assumes pin inputs are asynchronous levels and an APB master reaches the registers.
//
// The APB register port and the register offsets are this design's own decisions.
`default_nettype none

module crmc_top
  import crmc_pkg::*;
#(
  parameter int PCLK_DIV = CRMC_PCLK_DIV
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // APB slave port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CRMC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous pin inputs.
  input wire crmc_pin_in_t pin_in,
  // Pin outputs and their active-low output enables.
  output crmc_pin_out_t pin_out,
  output crmc_pin_out_t pin_oe_n
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Encodes the two active-low status lines for a system bus cycle.
  function automatic logic [1:0] bus_status(input logic is_write);
    bus_status = is_write ? CRMC_STATUS_WRITE : CRMC_STATUS_READ;
  endfunction

  // Matches a word address against one register offset.
  function automatic logic reg_hit(input logic [CRMC_ADDR_W-1:0] addr,
                                   input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  // ---------------------------------------------------------------------------
  // Pin input synchronisation
  // ---------------------------------------------------------------------------
  crmc_pin_in_t pins;
  logic [$bits(crmc_pin_in_t)-1:0] pins_raw;

  crmc_sync #(
    .WIDTH($bits(crmc_pin_in_t))
  ) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in(pin_in),
    .sync_out(pins_raw)
  );

  assign pins = crmc_pin_in_t'(pins_raw);

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic shadow_en;
  logic [CRMC_WAIT_W-1:0] slow_waits;
  logic [31:0] next_prdata;
  logic [31:0] status_word;
  logic [31:0] ctrl_word;
  wire hit_ctrl = reg_hit(paddr, CRMC_CTRL_OFS);
  wire hit_status = reg_hit(paddr, CRMC_STATUS_OFS);
  wire mapped = hit_ctrl | hit_status;
  wire setup_phase = psel & ~penable;
  wire access_phase = psel & penable;
  wire ctrl_write = access_phase & pwrite & hit_ctrl & pstrb[0];

  // Reset and cycle state that software may observe.
  logic cpu_reset_q;
  logic coproc_reset_q;
  logic cycle_busy;

  // The slave answers in the first access cycle; unmapped addresses give an error.
  assign pready = 1'b1;
  assign pslverr = access_phase & ~mapped;

  // Read views of the control and status registers.
  assign ctrl_word = {24'h00_0000, slow_waits, 3'b000, shadow_en};
  assign status_word = {26'h000_0000, shadow_en, cycle_busy, pins.output_float_test,
                        ~pins.turbo_n, coproc_reset_q, cpu_reset_q};

  // Read data is chosen during setup and held by a flip-flop for the access cycle.
  assign next_prdata = hit_ctrl ? ctrl_word :
                       hit_status ? status_word : 32'h0000_0000;

  // Control register: shadowing select and the non-turbo wait count.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      shadow_en <= CRMC_CTRL_RESET[CRMC_CTRL_SHADOW_BIT];
      slow_waits <= CRMC_CTRL_RESET[CRMC_CTRL_WAIT_LSB +: CRMC_WAIT_W];
    end else if (ctrl_write) begin
      shadow_en <= pwdata[CRMC_CTRL_SHADOW_BIT];
      slow_waits <= pwdata[CRMC_CTRL_WAIT_LSB +: CRMC_WAIT_W];
    end
  end

  // Read data register.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Reset outputs
  // ---------------------------------------------------------------------------
  // Either reset input resets the processor; only both together reset the coprocessor.
  wire next_cpu_reset = pins.system_reset_in | pins.cpu_only_reset_in; // R02 R03
  wire next_coproc_reset = pins.system_reset_in & pins.cpu_only_reset_in; // R01 R03

  // The synchroniser comes out of block reset holding zeros, so the reset outputs
  // stay asserted until it has filled; otherwise they would glitch low on release.
  logic [1:0] sync_fill;
  wire sync_full = (sync_fill == 2'(CRMC_SYNC_STAGES));

  // Counts the edges that fill the synchroniser after block reset.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync_fill <= 2'd0;
    end else if (!sync_full) begin
      sync_fill <= sync_fill + 2'd1;
    end
  end

  // Registered so that release is clean and aligned to the clock.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cpu_reset_q <= 1'b1; // R14
      coproc_reset_q <= 1'b1; // R14
    end else if (sync_full) begin
      cpu_reset_q <= next_cpu_reset; // R14
      coproc_reset_q <= next_coproc_reset; // R14
    end
  end

  // ---------------------------------------------------------------------------
  // Peripheral clock output
  // ---------------------------------------------------------------------------
  localparam int DIV_W = (PCLK_DIV > 2) ? $clog2(PCLK_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PCLK_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(PCLK_DIV / 2);
  logic [DIV_W-1:0] div_cnt;
  logic pclk_n_q;
  wire div_wrap = (div_cnt == DIV_LAST);
  wire [DIV_W-1:0] next_div_cnt = div_wrap ? '0 : div_cnt + 1'b1;

  // System reset holds the divider at phase zero, so every clock edge starts aligned.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      div_cnt <= '0;
      pclk_n_q <= 1'b1;
    end else if (pins.system_reset_in) begin
      div_cnt <= '0; // R04
      pclk_n_q <= 1'b1; // R04
    end else begin
      div_cnt <= next_div_cnt;
      pclk_n_q <= (next_div_cnt < DIV_HALF) ? 1'b0 : 1'b1; // R04
    end
  end

  // ---------------------------------------------------------------------------
  // Bus cycle control
  // ---------------------------------------------------------------------------
  crmc_state_t state;
  crmc_state_t next_state;
  logic req_prev;
  logic cyc_write;
  logic cyc_local;
  logic cyc_mem_io;
  logic cyc_rom;
  logic cyc_rom_hi;
  logic [CRMC_WAIT_W-1:0] wait_cnt;
  wire req_rise = pins.cycle_req & ~req_prev;
  wire rom_to_dram = pins.cycle_rom & shadow_en; // R06
  wire start_local = pins.cycle_local | rom_to_dram; // R06
  wire turbo = ~pins.turbo_n;
  wire [CRMC_WAIT_W-1:0] start_waits = turbo ? '0 : slow_waits; // R10 R11
  wire waits_done = (wait_cnt == '0);
  wire system_done = cyc_local | ~pins.legacy_ready_n;
  wire abort = next_cpu_reset;

  // Next state: a cycle starts on a request edge, waits out its count and ends in ready.
  always_comb begin
    next_state = state;
    case (state)
      CRMC_IDLE: begin
        if (req_rise) begin
          next_state = CRMC_START;
        end
      end
      CRMC_START: begin
        next_state = CRMC_WAIT;
      end
      CRMC_WAIT: begin
        if (waits_done && system_done) begin
          next_state = CRMC_DONE;
        end
      end
      CRMC_DONE: begin
        next_state = CRMC_IDLE;
      end
      default: begin
        next_state = CRMC_IDLE;
      end
    endcase
  end

  // State and request edge memory.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state <= CRMC_IDLE;
      req_prev <= 1'b0;
    end else begin
      state <= abort ? CRMC_IDLE : next_state;
      req_prev <= pins.cycle_req;
    end
  end

  // Cycle attributes are caught at the start; write/read comes from the processor.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cyc_write <= 1'b0;
      cyc_local <= 1'b0;
      cyc_mem_io <= 1'b0;
      cyc_rom <= 1'b0;
      cyc_rom_hi <= 1'b0;
    end else if (state == CRMC_IDLE && req_rise) begin
      cyc_write <= pins.write_read_sel; // R13
      cyc_local <= start_local;
      cyc_mem_io <= pins.cycle_mem_io;
      cyc_rom <= pins.cycle_rom & ~shadow_en; // R06
      cyc_rom_hi <= pins.cycle_rom_hi;
    end
  end

  // Wait state counter, loaded at the start from the turbo setting.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wait_cnt <= '0;
    end else if (state == CRMC_IDLE) begin
      wait_cnt <= start_waits; // R10 R11
    end else if (state == CRMC_WAIT && !waits_done) begin
      wait_cnt <= wait_cnt - 1'b1; // R11
    end
  end

  assign cycle_busy = (state != CRMC_IDLE);

  // ---------------------------------------------------------------------------
  // Cycle outputs
  // ---------------------------------------------------------------------------
  logic [1:0] status_n_q;
  logic rom0_n_q;
  logic rom1_n_q;
  logic we_n_q;
  logic ready_n_q;
  logic mem_io_q;
  wire start_sys = (state == CRMC_START) & ~cyc_local;
  wire in_cycle = (state == CRMC_START) | (state == CRMC_WAIT);
  wire rom_active = in_cycle & cyc_rom & ~shadow_en;
  wire [1:0] next_status_n = start_sys ? bus_status(cyc_write) : 2'b11; // R07

  // Registered cycle outputs.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      status_n_q <= 2'b11;
      rom0_n_q <= 1'b1;
      rom1_n_q <= 1'b1;
      we_n_q <= 1'b1;
      ready_n_q <= 1'b1;
      mem_io_q <= 1'b0;
    end else begin
      status_n_q <= next_status_n; // R07
      rom0_n_q <= ~(rom_active & ~cyc_rom_hi); // R05 R06
      rom1_n_q <= ~(rom_active & cyc_rom_hi); // R05 R06
      we_n_q <= ~(in_cycle & cyc_local & cyc_write); // R12
      ready_n_q <= ~(next_state == CRMC_DONE && state == CRMC_WAIT && !abort); // R10
      mem_io_q <= in_cycle ? cyc_mem_io : mem_io_q; // R07
    end
  end

  // ---------------------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------------------
  // Output values from flip-flops.
  assign pin_out.cpu_reset_out = cpu_reset_q;
  assign pin_out.coproc_reset_out = coproc_reset_q;
  assign pin_out.rom_select0_n = rom0_n_q;
  assign pin_out.rom_select1_n = rom1_n_q;
  assign pin_out.bus_status0_n = status_n_q[0];
  assign pin_out.bus_status1_n = status_n_q[1];
  assign pin_out.legacy_mem_io_select = mem_io_q;
  assign pin_out.dram_write_n = we_n_q;
  assign pin_out.ready_n = ready_n_q;
  assign pin_out.periph_clk_n = pclk_n_q;

  // The float test input disables every output buffer while it is high.
  assign pin_oe_n = pins.output_float_test ? '1 : '0; // R08

endmodule

`default_nettype wire

// *** shared/crmc_pkg.sv ***
// Constants, field layouts and carrier types for the reset and mode control block.
// Assumes a single 50 MHz clock domain and an APB register port with 32-bit data.
//
// Function
// R01: Coprocessor reset asserts only while system reset and processor-only reset both assert.
// R02: Processor reset asserts when either system reset or processor-only reset asserts.
// R03: Processor-only reset alone resets the processor and leaves the coprocessor running.
// R04: System reset restarts the generated peripheral clock so its phase is synchronised.
// R05: Two active-low ROM selects pick the boot ROM devices during initialisation.
// R06: With ROM shadowing on, ROM selects stay inactive and ROM accesses go to DRAM.
// R07: Bus status outputs mark a system bus cycle start and encode its type.
// R08: While the float test input is high, every output buffer is disabled.
// R09: The board holds both test inputs low; the second one is never driven high.
// R10: With turbo asserted, ready generation adds no wait states to local cycles.
// R11: With turbo deasserted, ready generation inserts extra wait states into every cycle.
// R12: The DRAM write strobe asserts for local writes and stays inactive for reads.
// R13: The processor drives write/read select to say whether a cycle writes or reads.
// R14: Reset outputs are registered on the internal clock for clean synchronous release.
`default_nettype none

package crmc_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int CRMC_ADDR_W = 8;
  localparam logic [7:0] CRMC_CTRL_OFS = 8'h00;
  localparam logic [7:0] CRMC_STATUS_OFS = 8'h04;

  // Control register fields and reset value.
  localparam int CRMC_CTRL_SHADOW_BIT = 0;
  localparam int CRMC_CTRL_WAIT_LSB = 4;
  localparam int CRMC_WAIT_W = 4;
  localparam logic [31:0] CRMC_CTRL_RESET = 32'h0000_0040;

  // Status register fields.
  localparam int CRMC_ST_CPU_RST_BIT = 0;
  localparam int CRMC_ST_NPX_RST_BIT = 1;
  localparam int CRMC_ST_TURBO_BIT = 2;
  localparam int CRMC_ST_FLOAT_BIT = 3;
  localparam int CRMC_ST_BUSY_BIT = 4;
  localparam int CRMC_ST_SHADOW_BIT = 5;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CRMC_SYNC_STAGES = 2;
  localparam int CRMC_PCLK_DIV = 2;
  localparam logic [1:0] CRMC_STATUS_WRITE = 2'b10;
  localparam logic [1:0] CRMC_STATUS_READ = 2'b01;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  // Pin inputs, used both for the asynchronous pins and for the levels after the synchroniser.
  typedef struct packed {
    logic system_reset_in;
    logic cpu_only_reset_in;
    logic output_float_test;
    logic reserved_test_in;
    logic turbo_n;
    logic write_read_sel;
    logic legacy_ready_n;
    logic cycle_req;
    logic cycle_local;
    logic cycle_mem_io;
    logic cycle_rom;
    logic cycle_rom_hi;
  } crmc_pin_in_t;

  // Output pin group; the enable group uses the same layout.
  typedef struct packed {
    logic cpu_reset_out;
    logic coproc_reset_out;
    logic rom_select0_n;
    logic rom_select1_n;
    logic bus_status0_n;
    logic bus_status1_n;
    logic legacy_mem_io_select;
    logic dram_write_n;
    logic ready_n;
    logic periph_clk_n;
  } crmc_pin_out_t;

  typedef enum logic [1:0] {
    CRMC_IDLE = 2'b00,
    CRMC_START = 2'b01,
    CRMC_WAIT = 2'b10,
    CRMC_DONE = 2'b11
  } crmc_state_t;

endpackage

`default_nettype wire

// *** tb/crmc_cpu_model.sv ***
// Processor and peripheral side of the bus cycle handshake.
// Assumes go pulses for one cycle only while busy is low.
`default_nettype none
module crmc_cpu_model
  import crmc_pkg::*;
(
  // Clock and request from the bench.
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [4:0] kind,
  input wire logic [3:0] slow,
  // Block outputs and the levels the model drives.
  input wire crmc_pin_out_t pin_out,
  output logic busy,
  output logic [15:0] lat,
  output logic [4:0] attr,
  output logic creq,
  output logic lrdy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Holds attributes until ready, answers system cycles after slow cycles,
  // and toggles the idle attribute lines so stale values are never trusted.
  initial begin
    busy = 1'b0;
    lat = '0;
    attr = '0;
    creq = 1'b0;
    lrdy_n = 1'b1;
    forever begin
      @(posedge sys_clk);
      if (busy) begin
        lat <= lat + 16'd1;
        if (!pin_out.ready_n) begin
          creq <= 1'b0;
          lrdy_n <= 1'b1;
          busy <= 1'b0;
        end else if (!attr[3] && lat == {12'h000, slow}) begin
          lrdy_n <= 1'b0;
        end
      end else if (go) begin
        busy <= 1'b1;
        attr <= kind;
        creq <= 1'b1;
        lat <= '0;
      end else begin
        attr <= ~attr;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/crmc_sva.sv ***
// Checker for crmc_top, bound from the bench top file.
// Assumes pin levels stay steady for several cycles around each change.
`default_nettype none
module crmc_sva
  import crmc_pkg::*;
(
  // Clock, reset and APB.
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic [CRMC_ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Pins.
  input wire crmc_pin_in_t pin_in,
  input wire crmc_pin_out_t pin_out,
  input wire crmc_pin_out_t pin_oe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [1:0] up;
  // Counts edges after reset so the three-edge pin path is filled first.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) up <= 2'd0;
    else if (up != 2'd3) up <= up + 2'd1;
  end
  sequence s_local_req;
    $rose(pin_in.cycle_req) && pin_in.cycle_local;
  endsequence
  a_cpu_reset_or: assert property (up == 2'd3 |-> pin_out.cpu_reset_out ==
    ($past(pin_in.system_reset_in, 3) | $past(pin_in.cpu_only_reset_in, 3)))
    else $error("processor reset output wrong");
  a_coproc_reset_and: assert property (up == 2'd3 |-> pin_out.coproc_reset_out ==
    ($past(pin_in.system_reset_in, 3) & $past(pin_in.cpu_only_reset_in, 3)))
    else $error("coprocessor reset output wrong");
  a_float_all_off: assert property (pin_in.output_float_test [*4] |-> &pin_oe_n)
    else $error("output enable active while floating");
  a_float_all_on: assert property (!pin_in.output_float_test [*4] |-> pin_oe_n == '0)
    else $error("output enable off without float");
  a_turbo_no_wait: assert property (s_local_req and !pin_in.turbo_n |->
    pin_out.ready_n [*3] ##[1:4] !pin_out.ready_n)
    else $error("turbo local cycle ready late or early");
  a_slow_waits: assert property (s_local_req and pin_in.turbo_n |-> pin_out.ready_n [*7])
    else $error("non turbo cycle without added waits");
  a_strobe_write: assert property (!pin_out.dram_write_n |->
    pin_in.write_read_sel && pin_in.cycle_req)
    else $error("write strobe outside a write cycle");
  a_status_code: assert property (!(pin_out.bus_status0_n && pin_out.bus_status1_n) |->
    {pin_out.bus_status1_n, pin_out.bus_status0_n} == (pin_in.write_read_sel ?
    CRMC_STATUS_WRITE : CRMC_STATUS_READ) && !pin_in.cycle_local ##1
    (pin_out.bus_status0_n && pin_out.bus_status1_n))
    else $error("bus status code wrong");
  a_rom_low_pick: assert property (!pin_out.rom_select0_n |-> pin_in.cycle_rom &&
    !pin_in.cycle_rom_hi && pin_out.rom_select1_n)
    else $error("low ROM select outside its range");
  a_pclk_held: assert property (pin_in.system_reset_in [*4] |-> pin_out.periph_clk_n)
    else $error("peripheral clock runs during system reset");
  a_pclk_runs: assert property (!pin_in.system_reset_in [*4] |->
    ##[0:2] $changed(pin_out.periph_clk_n))
    else $error("peripheral clock stuck outside system reset");
  a_apb_unmapped: assert property (psel && penable |-> pready && (pslverr ==
    (paddr != CRMC_CTRL_OFS && paddr != CRMC_STATUS_OFS)))
    else $error("APB answer wrong");
endmodule
`default_nettype wire

// *** tb/crmc_tb_top.sv ***
// Bench for crmc_top: registers over APB, reset pins, bus cycles and float.
// Uses crmc_cpu_model as the processor side and binds crmc_sva.
`default_nettype none
module crmc_tb_top import crmc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err, pready, pslverr;
  logic sys_r = 1, cpu_r = 1, flt = 0, turbo_n = 0, go = 0, busy, creq, lrdy_n;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic [4:0] kind = '0, attr;
  logic [3:0] slow = '0;
  logic [15:0] lat, t0;
  logic [2:0] seen = '0;
  logic [1:0] st = 2'b11;
  crmc_pin_in_t pin_in;
  crmc_pin_out_t pin_out, pin_oe_n;
  int err_total = 0, num_checks = 0, cyc_cnt = 0;
  initial forever #10 sys_clk = ~sys_clk;
  // Kind bits are write, local, memory, ROM range and high ROM.
  assign pin_in = '{system_reset_in: sys_r, cpu_only_reset_in: cpu_r,
    output_float_test: flt, reserved_test_in: 1'b0, turbo_n: turbo_n,
    write_read_sel: attr[4], legacy_ready_n: lrdy_n, cycle_req: creq,
    cycle_local: attr[3], cycle_mem_io: attr[2], cycle_rom: attr[1], cycle_rom_hi: attr[0]};
  crmc_top u_dut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n));
  crmc_cpu_model u_cpu (.sys_clk(sys_clk), .go(go), .kind(kind), .slow(slow),
    .pin_out(pin_out), .busy(busy), .lat(lat), .attr(attr), .creq(creq), .lrdy_n(lrdy_n));
  // Latches the write strobe and ROM selects, and the single-cycle status codes.
  always @(posedge sys_clk) begin
    if (!pin_out.dram_write_n) seen[2] <= 1'b1;
    if (!pin_out.rom_select0_n) seen[1] <= 1'b1;
    if (!pin_out.rom_select1_n) seen[0] <= 1'b1;
    if (!(pin_out.bus_status0_n && pin_out.bus_status1_n)) st <= {pin_out.bus_status1_n,
      pin_out.bus_status0_n};
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 3000) begin
      err_total++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] a, input logic [31:0] b);
    num_checks++;
    if (a !== b) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, a, b);
    end
  endtask
  // One APB transfer; entered just after a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  // One bus cycle through the model; leaves its latency in lat.
  task automatic cyc(input logic [4:0] k, input logic [3:0] s);
    seen = '0;
    kind <= k;
    slow <= s;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    while (busy) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic final_report();
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    // Every reset input pair, ending with both released.
    for (int i = 3; i >= 0; i--) begin
      sys_r <= i[1];
      cpu_r <= i[0];
      repeat (5) @(posedge sys_clk);
      chk({pin_out.coproc_reset_out, pin_out.cpu_reset_out}, {i[1] & i[0], i[1] | i[0]});
      apb(1'b0, CRMC_STATUS_OFS, '0);
      chk(q, {26'h0, 4'b0001, i[1] & i[0], i[1] | i[0]});
    end
    apb(1'b0, CRMC_CTRL_OFS, '0);
    chk(q, CRMC_CTRL_RESET);
    apb(1'b1, CRMC_STATUS_OFS, 32'hFFFF_FFFF);
    apb(1'b0, CRMC_STATUS_OFS, '0);
    chk(q, 32'h0000_0004);
    apb(1'b0, 8'h08, '0);
    chk({31'h0, err} | q, 32'h0000_0001);
    cyc(5'b11000, 4'h0);
    t0 = lat;
    chk(seen, 3'b100);
    cyc(5'b01000, 4'h0);
    chk({seen, lat}, {3'b000, t0});
    turbo_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    cyc(5'b11000, 4'h0);
    chk(lat, t0 + 16'd4);
    apb(1'b1, CRMC_CTRL_OFS, 32'h0000_0080);
    cyc(5'b01000, 4'h0);
    chk(lat, t0 + 16'd8);
    turbo_n <= 1'b0;
    cyc(5'b10100, 4'h3);
    chk({st, pin_out.legacy_mem_io_select}, {CRMC_STATUS_WRITE, 1'b1});
    cyc(5'b00000, 4'h0);
    chk({st, pin_out.legacy_mem_io_select}, {CRMC_STATUS_READ, 1'b0});
    cyc(5'b00110, 4'h0);
    chk(seen, 3'b010);
    cyc(5'b00111, 4'h1);
    chk(seen, 3'b001);
    apb(1'b1, CRMC_CTRL_OFS, 32'h0000_0041);
    cyc(5'b00111, 4'h0);
    chk(seen, 3'b000);
    flt <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk(32'(pin_oe_n), 32'h0000_03FF);
    flt <= 1'b0;
    repeat (5) @(posedge sys_clk);
    chk(32'(pin_oe_n), 32'h0000_0000);
    final_report();
  end
endmodule
bind crmc_top crmc_sva u_sva (.sys_clk(sys_clk), .reset(reset), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n));
`default_nettype wire
